// *** inc/fsr_consts.vh ***
`ifndef FSR_CONSTS_VH
`define FSR_CONSTS_VH

// ********************************************************************
// Instruction codes
// ********************************************************************
`define FSR_OP_ID_SINGLE 8'h90
`define FSR_OP_ID_DUAL 8'h92
`define FSR_OP_ID_QUAD 8'h94
`define FSR_OP_UNIQUE_ID 8'h4B
`define FSR_OP_JEDEC_ID 8'h9F
`define FSR_OP_PARAM_TABLE 8'h5A
`define FSR_OP_SECREG_ERASE 8'h44
`define FSR_OP_SECREG_PROG 8'h42

// ********************************************************************
// Serial clock counts (rising edges since chip select fell)
// ********************************************************************
`define FSR_OPCODE_END 12'h008
`define FSR_ADDR_END_SINGLE 12'h020
`define FSR_ADDR_END_DUAL 12'h014
`define FSR_MODE_END_DUAL 12'h018
`define FSR_ADDR_END_QUAD 12'h00E
`define FSR_DUMMY_END_QUAD 12'h014
`define FSR_UID_DUMMY_END 12'h028
`define FSR_TABLE_DUMMY_END 12'h028

// ********************************************************************
// Security register address layout
// ********************************************************************
`define FSR_SEL_HI 15
`define FSR_SEL_LO 12
`define FSR_SEL_FIRST 4'h1
`define FSR_SEL_LAST 4'h3
`define FSR_ERASED_BYTE 8'hFF

// ********************************************************************
// Timing
// ********************************************************************
`define FSR_CLK_PERIOD_NS 100
`define FSR_NV_TICK_LAST 2'h3

`endif

// *** verilog/fsr_buf2.v ***
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer; in_ready drops only when both entries hold data
module fsr_buf2 #(
    parameter W = 18
) (
    // Clock and reset
    input wire clock_in,
    input wire nrst_in,
    // Filling side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [W-1:0] in_data_in,
    // Draining side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [W-1:0] out_data_out
);

    reg [W-1:0] head_reg;
    reg [W-1:0] tail_reg;
    reg [1:0] count_reg;
    wire push;
    wire pop;

    // Handshakes on both sides
    assign in_ready_out = (count_reg != 2'h2);
    assign out_valid_out = (count_reg != 2'h0);
    assign out_data_out = head_reg;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Head is always the oldest entry, so the drain side sees it directly
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            head_reg <= {W{1'b0}};
            tail_reg <= {W{1'b0}};
            count_reg <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count_reg == 2'h0) begin
                        head_reg <= in_data_in;
                    end else begin
                        tail_reg <= in_data_in;
                    end
                    count_reg <= count_reg + 2'h1;
                end
                2'b01: begin
                    head_reg <= tail_reg;
                    count_reg <= count_reg - 2'h1;
                end
                2'b11: begin
                    if (count_reg == 2'h1) begin
                        head_reg <= in_data_in;
                    end else begin
                        head_reg <= tail_reg;
                        tail_reg <= in_data_in;
                    end
                end
                default: begin
                    count_reg <= count_reg;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// *** verilog/fsr_sec_id.v ***
// Notes on behaviour
// - Opcode 90h with address 000000h returns manufacturer then device ID.
// - Address 000001h on a 90h, 92h or 94h read swaps the order: device ID first.
// - ID bytes keep alternating until chip select goes high.
// - Opcode 92h takes address and mode bits two per clock, answers two.
// - Opcode 94h takes address and mode four per clock, four dummies.
// - Opcode 4Bh takes 32 dummy clocks, then shifts out 64-bit identifier.
// - Opcode 9Fh returns manufacturer, memory type, capacity, MSB first.
// - Opcode 5Ah: address, eight dummies, table data from 40th falling edge.
// - Table address bits 7..0 pick the start byte of a 256-byte table.
// - Opcode 44h erases; address bits 15..12 select register 1, 2 or 3.
// - Erase and program are accepted only with the write latch set.
// - Erase runs only if chip select rises right after address bit 24.
// - Erase is self-timed; busy is high throughout and drops at the end.
// - Finished erase clears the write-enable latch.
// - A set lock bit makes erase and program to that register ignored.
// - Opcode 42h programs 1..256 bytes into erased locations, same coding.
// - Inputs are taken on rising clock edges, outputs change on falling.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_consts.vh"

module fsr_sec_id #(
    parameter [7:0] MFR_ID = 8'hC3,       // Arbitrary value
    parameter [7:0] DEV_ID = 8'h13,       // Arbitrary value
    parameter [7:0] MEM_TYPE = 8'h40,     // Arbitrary value
    parameter [7:0] CAPACITY = 8'h14,     // Arbitrary value
    parameter [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // Arbitrary
    parameter T_ERASE_NS = 100000,
    parameter T_PROG_NS = 70000
) (
    // Clock and reset
    input wire clock_in,
    input wire nrst_in,
    // Serial link pins
    input wire spi_cs_n_in,
    input wire spi_sck_in,
    input wire [3:0] spi_io_in,
    output reg [3:0] spi_io_out,
    output reg [3:0] spi_io_oe_out,
    // Status register interface
    input wire write_enable_latch_in,
    input wire [3:1] secreg_lock_bits_in,
    output reg busy_out,
    output reg latch_clear_out
);

    // ****************************************************************
    // Constants and functions
    // ****************************************************************
    localparam integer ERASE_CYCLES =
        (T_ERASE_NS + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS;
    localparam integer PROG_CYCLES =
        (T_PROG_NS + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS;
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ERASE = 2'h1;
    localparam [1:0] ST_PROG = 2'h2;

    // Lanes used by the answer of a read instruction
    function [2:0] out_lanes(input [7:0] op);
        begin
            if (op == `FSR_OP_ID_DUAL) begin
                out_lanes = 3'h2;
            end else if (op == `FSR_OP_ID_QUAD) begin
                out_lanes = 3'h4;
            end else begin
                out_lanes = 3'h1;
            end
        end
    endfunction

    // Rising-edge count after which the answer starts; zero means none
    function [11:0] out_start(input [7:0] op);
        begin
            case (op)
                `FSR_OP_ID_SINGLE: out_start = `FSR_ADDR_END_SINGLE;
                `FSR_OP_ID_DUAL: out_start = `FSR_MODE_END_DUAL;
                `FSR_OP_ID_QUAD: out_start = `FSR_DUMMY_END_QUAD;
                `FSR_OP_UNIQUE_ID: out_start = `FSR_UID_DUMMY_END;
                `FSR_OP_JEDEC_ID: out_start = `FSR_OPCODE_END;
                `FSR_OP_PARAM_TABLE: out_start = `FSR_TABLE_DUMMY_END;
                default: out_start = 12'h000;
            endcase
        end
    endfunction

    // Address lanes on rising edge k; zero outside the address phase
    function [2:0] addr_lanes(input [7:0] op, input [11:0] k);
        begin
            addr_lanes = 3'h0;
            if (k > `FSR_OPCODE_END) begin
                if (op == `FSR_OP_ID_DUAL) begin
                    if (k <= `FSR_ADDR_END_DUAL) addr_lanes = 3'h2;
                end else if (op == `FSR_OP_ID_QUAD) begin
                    if (k <= `FSR_ADDR_END_QUAD) addr_lanes = 3'h4;
                end else if (k <= `FSR_ADDR_END_SINGLE) begin
                    addr_lanes = 3'h1;
                end
            end
        end
    endfunction

    // Parameter table contents: signature, revision, then erased bytes
    function [7:0] table_byte(input [7:0] a);
        begin
            case (a)
                8'h00: table_byte = 8'h53;
                8'h01: table_byte = 8'h46;
                8'h02: table_byte = 8'h44;
                8'h03: table_byte = 8'h50;
                8'h04: table_byte = 8'h00;
                8'h05: table_byte = 8'h01;
                8'h06: table_byte = 8'h00;
                default: table_byte = `FSR_ERASED_BYTE;
            endcase
        end
    endfunction

    // Next answer byte for the running read
    function [7:0] answer_byte(input [7:0] op, input [11:0] idx,
                               input [23:0] addr);
        begin
            case (op)
                `FSR_OP_UNIQUE_ID:
                    answer_byte = UNIQUE_ID[(7 - idx[2:0]) * 8 +: 8];
                `FSR_OP_JEDEC_ID: begin
                    if (idx == 12'h000) begin
                        answer_byte = MFR_ID;
                    end else if (idx == 12'h001) begin
                        answer_byte = MEM_TYPE;
                    end else begin
                        answer_byte = CAPACITY;
                    end
                end
                `FSR_OP_PARAM_TABLE:
                    answer_byte = table_byte(addr[7:0] + idx[7:0]);
                default: begin
                    // Order flips when address bit 0 is set
                    if (idx[0] ^ addr[0]) begin
                        answer_byte = DEV_ID;
                    end else begin
                        answer_byte = MFR_ID;
                    end
                end
            endcase
        end
    endfunction

    // Register select valid, bits 23..16 and 11..8 zero, and not locked
    function secreg_ok(input [23:0] a, input [3:1] lock);
        begin
            secreg_ok = (a[23:16] == 8'h00) && (a[11:8] == 4'h0) &&
                (a[`FSR_SEL_HI:`FSR_SEL_LO] >= `FSR_SEL_FIRST) &&
                (a[`FSR_SEL_HI:`FSR_SEL_LO] <= `FSR_SEL_LAST) &&
                !lock[a[13:12]];
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    reg cs_s1_reg, cs_s2_reg, cs_d_reg;
    reg sck_s1_reg, sck_s2_reg, sck_d_reg;
    reg [3:0] io_s1_reg, io_s2_reg;
    wire sck_rise;
    wire sck_fall;
    wire cs_rise;

    // Two flops on every pin; the link clock is slow enough to sample
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_d_reg <= 1'b1;
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            io_s1_reg <= 4'h0;
            io_s2_reg <= 4'h0;
        end else begin
            cs_s1_reg <= spi_cs_n_in;
            cs_s2_reg <= cs_s1_reg;
            cs_d_reg <= cs_s2_reg;
            sck_s1_reg <= spi_sck_in;
            sck_s2_reg <= sck_s1_reg;
            sck_d_reg <= sck_s2_reg;
            io_s1_reg <= spi_io_in;
            io_s2_reg <= io_s1_reg;
        end
    end

    assign sck_rise = !cs_s2_reg && sck_s2_reg && !sck_d_reg;
    assign sck_fall = !cs_s2_reg && !sck_s2_reg && sck_d_reg;
    assign cs_rise = cs_s2_reg && !cs_d_reg;

    // ****************************************************************
    // Command decode and answer shifting
    // ****************************************************************
    reg [7:0] op_reg;
    reg [23:0] addr_reg;
    reg [11:0] rise_cnt_reg;
    reg [11:0] out_idx_reg;
    reg [7:0] out_shift_reg;
    reg [3:0] out_left_reg;
    reg [7:0] data_shift_reg;
    reg [2:0] data_bits_reg;
    reg [7:0] prog_ptr_reg;
    reg prog_ok_reg;
    reg prog_any_reg;
    reg [11:0] rise_next;
    reg [7:0] cur_byte;
    reg [11:0] idx_next;
    reg [2:0] lanes;
    reg [2:0] alanes;
    reg [7:0] data_next;
    wire buf_in_ready;
    wire buf_in_valid;
    wire [17:0] buf_in_data;

    // Current answer byte, fresh when the previous one is used up
    always @* begin
        rise_next = (rise_cnt_reg == 12'hFFF) ? rise_cnt_reg :
            rise_cnt_reg + 12'h001;
        lanes = out_lanes(op_reg);
        alanes = addr_lanes(op_reg, rise_next);
        cur_byte = out_shift_reg;
        idx_next = out_idx_reg;
        data_next = {data_shift_reg[6:0], io_s2_reg[0]};
        if (out_left_reg == 4'h0) begin
            cur_byte = answer_byte(op_reg, out_idx_reg, addr_reg);
            idx_next = out_idx_reg + 12'h001;
            if (op_reg == `FSR_OP_JEDEC_ID && out_idx_reg == 12'h002) begin
                idx_next = 12'h000;
            end
        end
    end

    // Program bytes enter the buffer with register bank and byte address
    assign buf_in_valid = sck_rise && prog_ok_reg &&
        (op_reg == `FSR_OP_SECREG_PROG) &&
        (rise_cnt_reg >= `FSR_ADDR_END_SINGLE) && (data_bits_reg == 3'h7);
    assign buf_in_data = {addr_reg[13:12] - 2'h1, prog_ptr_reg, data_next};

    // Inputs on rising edges, answers on falling edges
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            op_reg <= 8'h00;
            addr_reg <= 24'h00_0000;
            rise_cnt_reg <= 12'h000;
            out_idx_reg <= 12'h000;
            out_shift_reg <= 8'h00;
            out_left_reg <= 4'h0;
            data_shift_reg <= 8'h00;
            data_bits_reg <= 3'h0;
            prog_ptr_reg <= 8'h00;
            prog_ok_reg <= 1'b0;
            prog_any_reg <= 1'b0;
            spi_io_out <= 4'h0;
            spi_io_oe_out <= 4'h0;
        end else if (cs_s2_reg) begin
            // Chip select high ends any command and frees the pins
            rise_cnt_reg <= 12'h000;
            out_idx_reg <= 12'h000;
            out_left_reg <= 4'h0;
            data_bits_reg <= 3'h0;
            prog_ok_reg <= 1'b0;
            spi_io_oe_out <= 4'h0;
            if (!cs_rise) begin
                prog_any_reg <= 1'b0;
            end
        end else if (sck_rise) begin
            rise_cnt_reg <= rise_next;
            if (rise_next <= `FSR_OPCODE_END) begin
                op_reg <= {op_reg[6:0], io_s2_reg[0]};
            end else if (alanes == 3'h1) begin
                addr_reg <= {addr_reg[22:0], io_s2_reg[0]};
            end else if (alanes == 3'h2) begin
                addr_reg <= {addr_reg[21:0], io_s2_reg[1:0]};
            end else if (alanes == 3'h4) begin
                addr_reg <= {addr_reg[19:0], io_s2_reg};
            end
            // Write latch, select and lock are judged once address is in
            if (rise_next == `FSR_ADDR_END_SINGLE) begin
                prog_ok_reg <= write_enable_latch_in && !busy_out &&
                    secreg_ok({addr_reg[22:0], io_s2_reg[0]},
                              secreg_lock_bits_in);
                prog_ptr_reg <= {addr_reg[6:0], io_s2_reg[0]};
            end
            if (op_reg == `FSR_OP_SECREG_PROG &&
                    rise_cnt_reg >= `FSR_ADDR_END_SINGLE) begin
                data_shift_reg <= data_next;
                data_bits_reg <= data_bits_reg + 3'h1;
                if (buf_in_valid) begin
                    // A full buffer cancels the rest of the program
                    prog_ok_reg <= buf_in_ready;
                    prog_any_reg <= buf_in_ready;
                    prog_ptr_reg <= prog_ptr_reg + 8'h01;
                end
            end
        end else if (sck_fall && out_start(op_reg) != 12'h000 &&
                rise_cnt_reg >= out_start(op_reg)) begin
            out_idx_reg <= idx_next;
            out_shift_reg <= cur_byte << lanes;
            out_left_reg <= ((out_left_reg == 4'h0) ? 4'h8 : out_left_reg)
                - {1'b0, lanes};
            if (lanes == 3'h4) begin
                spi_io_out <= cur_byte[7:4];
                spi_io_oe_out <= 4'hF;
            end else if (lanes == 3'h2) begin
                spi_io_out <= {2'b00, cur_byte[7:6]};
                spi_io_oe_out <= 4'h3;
            end else begin
                spi_io_out <= {2'b00, cur_byte[7], 1'b0};
                spi_io_oe_out <= 4'h2;
            end
        end
    end

    // ****************************************************************
    // Security register store and self-timed cycles
    // ****************************************************************
    reg [7:0] secreg_mem [0:767];
    reg [1:0] state_reg;
    reg [15:0] timer_reg;
    reg [1:0] erase_bank_reg;
    reg [7:0] erase_ptr_reg;
    reg erase_sweep_reg;
    reg [1:0] tick_cnt_reg;
    wire nv_tick;
    wire buf_out_valid;
    wire buf_out_ready;
    wire [17:0] buf_out_data;
    wire erase_start;

    // Slow pacing of program writes; at most one every fourth clock, while the erase sweep writes every clock
    assign nv_tick = (tick_cnt_reg == `FSR_NV_TICK_LAST);
    assign buf_out_ready = nv_tick && !erase_sweep_reg;
    // Erase only when chip select rises straight after address bit 24
    assign erase_start = cs_rise && op_reg == `FSR_OP_SECREG_ERASE &&
        rise_cnt_reg == `FSR_ADDR_END_SINGLE && write_enable_latch_in &&
        state_reg == ST_IDLE &&
        secreg_ok(addr_reg, secreg_lock_bits_in);

    fsr_buf2 #(
        .W(18)
    ) u_prog_buf (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .in_valid_in(buf_in_valid),
        .in_ready_out(buf_in_ready),
        .in_data_in(buf_in_data),
        .out_valid_out(buf_out_valid),
        .out_ready_in(buf_out_ready),
        .out_data_out(buf_out_data)
    );

    // Programming only clears bits, so a byte is ANDed into the cell
    always @(posedge clock_in) begin
        if (erase_sweep_reg) begin
            secreg_mem[{erase_bank_reg, erase_ptr_reg}] <= `FSR_ERASED_BYTE;
        end else if (buf_out_valid && buf_out_ready) begin
            secreg_mem[buf_out_data[17:8]] <=
                secreg_mem[buf_out_data[17:8]] & buf_out_data[7:0];
        end
    end

    // Busy cycle; the timer, the erase sweep and the buffer drain must all finish
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= ST_IDLE;
            timer_reg <= 16'h0000;
            erase_bank_reg <= 2'h0;
            erase_ptr_reg <= 8'h00;
            erase_sweep_reg <= 1'b0;
            tick_cnt_reg <= 2'h0;
            busy_out <= 1'b0;
            latch_clear_out <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 2'h1;
            latch_clear_out <= 1'b0;
            if (erase_sweep_reg) begin
                erase_ptr_reg <= erase_ptr_reg + 8'h01;
                erase_sweep_reg <= (erase_ptr_reg != 8'hFF);
            end
            case (state_reg)
                ST_IDLE: begin
                    if (erase_start) begin
                        state_reg <= ST_ERASE;
                        timer_reg <= ERASE_CYCLES[15:0];
                        erase_bank_reg <= addr_reg[13:12] - 2'h1;
                        erase_ptr_reg <= 8'h00;
                        erase_sweep_reg <= 1'b1;
                        busy_out <= 1'b1;
                    end else if (cs_rise && prog_any_reg &&
                            op_reg == `FSR_OP_SECREG_PROG) begin
                        state_reg <= ST_PROG;
                        timer_reg <= PROG_CYCLES[15:0];
                        busy_out <= 1'b1;
                    end
                end
                default: begin
                    if (timer_reg != 16'h0000) begin
                        timer_reg <= timer_reg - 16'h0001;
                    end else if (!erase_sweep_reg && !buf_out_valid) begin
                        state_reg <= ST_IDLE;
                        busy_out <= 1'b0;
                        latch_clear_out <= 1'b1;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// *** verif/fsr_sec_id_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsr_sec_id_asserts (
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Link pins
    input wire logic spi_cs_n_in,
    input wire logic spi_sck_in,
    input wire logic [3:0] spi_io_in,
    input wire logic [3:0] spi_io_out,
    input wire logic [3:0] spi_io_oe_out,
    // Status side
    input wire logic write_enable_latch_in,
    input wire logic [3:1] secreg_lock_bits_in,
    input wire logic busy_out,
    input wire logic latch_clear_out
);
    // ********
    // Link and self-timed cycle checks
    // ********
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // Start and end of a self-timed cycle
    sequence nv_start; $rose(busy_out); endsequence
    sequence nv_end; $fell(busy_out) ##1 !latch_clear_out; endsequence
    a_oe_off_idle: assert property (spi_cs_n_in [*6] |->
        spi_io_oe_out == 4'h0) else $error("lanes driven while idle");
    a_oe_lane_set: assert property (spi_io_oe_out inside
        {4'h0, 4'h2, 4'h3, 4'hF}) else $error("odd lane enable");
    // Sync delay puts every update a few clocks after the fall
    a_out_on_fall: assert property (!spi_cs_n_in &&
        $changed(spi_io_out) |-> !$past(spi_sck_in, 2))
        else $error("output moved on a rising edge");
    a_busy_cs_high: assert property (nv_start |-> spi_cs_n_in &&
        $past(spi_cs_n_in, 2)) else $error("busy while selected");
    a_busy_needs_wel: assert property (nv_start |->
        write_enable_latch_in) else $error("busy without latch");
    a_busy_holds: assert property (nv_start |-> busy_out [*8])
        else $error("busy too short");
    a_end_clears: assert property ($fell(busy_out) |->
        latch_clear_out) else $error("no latch clear at end");
    a_clear_pulse: assert property (latch_clear_out |-> nv_end)
        else $error("stray latch clear");
endmodule
bind fsr_sec_id fsr_sec_id_asserts i_chk (.clock_in(clock_in),
    .nrst_in(nrst_in), .spi_cs_n_in(spi_cs_n_in), .spi_sck_in(spi_sck_in),
    .spi_io_in(spi_io_in), .spi_io_out(spi_io_out),
    .spi_io_oe_out(spi_io_oe_out),
    .write_enable_latch_in(write_enable_latch_in),
    .secreg_lock_bits_in(secreg_lock_bits_in), .busy_out(busy_out),
    .latch_clear_out(latch_clear_out));
`default_nettype wire

// *** verif/fsr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
    // Clock
    input wire logic clock_in,
    // Link
    input wire logic [3:0] io_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic [3:0] io_out
);
    // Serial clock idles low, stands still between frames
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        io_out = 4'h0;
    end
    // One clock: lanes set while low; released lanes toggle so no
    // stale level can pass for an answer
    task cyc(input logic [3:0] v, input logic rel, output logic [3:0] q);
        io_out = rel ? ~io_out : v;
        repeat (4) @(negedge clock_in);
        sck_out = 1'b1;
        repeat (4) @(negedge clock_in);
        q = io_in;
        sck_out = 1'b0;
    endtask
    // Select stays low until desel, through the last data byte
    task sel();
        @(negedge clock_in);
        cs_n_out = 1'b0;
        repeat (4) @(negedge clock_in);
    endtask
    task desel();
        cs_n_out = 1'b1;
        repeat (8) @(negedge clock_in);
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fsr_consts.vh"
module tb;
    // Identity values are arbitrary
    localparam logic [7:0] MFR = 8'hA7;
    localparam logic [7:0] DEV = 8'h2C;
    localparam logic [7:0] TYP = 8'h51;
    localparam logic [7:0] CAP = 8'h0E;
    localparam logic [63:0] UID = 64'hFEDC_BA98_7654_3210;
    localparam logic [7:0] ERA = `FSR_OP_SECREG_ERASE;
    localparam logic [7:0] PRG = `FSR_OP_SECREG_PROG;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wlat = 1'b0;
    logic [3:1] lock = 3'h0;
    wire cs_n;
    wire sck;
    wire busy;
    wire wclr;
    wire [3:0] hio;
    wire [3:0] dout;
    wire [3:0] oe;
    wire [3:0] io_w;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [63:0] r;
    // Each lane carries whoever enables it
    assign io_w = (oe & dout) | (~oe & hio);
    always #50 clk = ~clk;
    // Short self-timed cycles keep the run brief
    fsr_sec_id #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(TYP),
        .CAPACITY(CAP), .UNIQUE_ID(UID), .T_ERASE_NS(30000),
        .T_PROG_NS(2000)) i_dut (.clock_in(clk), .nrst_in(nrst),
        .spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_io_in(io_w),
        .spi_io_out(dout), .spi_io_oe_out(oe),
        .write_enable_latch_in(wlat), .secreg_lock_bits_in(lock),
        .busy_out(busy), .latch_clear_out(wclr));
    fsr_host i_host (.clock_in(clk), .io_in(io_w), .cs_n_out(cs_n),
        .sck_out(sck), .io_out(hio));
    task tally_and_finish();
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] got, input logic [63:0] e);
        cmp_count++;
        if (got !== e) begin
            errors++;
            $display("wrong value %s exp %h got %h", nm, e, got);
        end
    endtask
    // Shift n bits of v on w lanes MSB first, gather answer lanes in r
    task xfer(input int w, input int n, input logic [63:0] v,
              input logic rel);
        logic [3:0] t;
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        for (int i = n; i > 0; i -= w) begin
            i_host.cyc(4'(v >> (i - w)) & m, rel, t);
            r = (w == 1) ? {r[62:0], t[1]} : (r << w) | 64'(t & m);
        end
    endtask
    // Opcode, address/mode, dummies, answer; select left low
    task run(input logic [7:0] op, input int w, input int na,
             input logic [63:0] a, input int nd, input int nr);
        i_host.sel();
        xfer(1, 8, 64'(op), 1'b0);
        xfer(w, na, a, 1'b0);
        xfer(1, nd, 64'h0, 1'b1);
        r = 64'h0;
        xfer(w, nr, 64'h0, 1'b1);
    endtask
    task rd(input string nm, input logic [7:0] op, input int w,
            input int na, input logic [63:0] a, input int nd, input int nr,
            input logic [63:0] e);
        run(op, w, na, a, nd, nr);
        chk(nm, r, e);
        i_host.desel();
    endtask
    // Erase or program attempt; e says whether a busy cycle follows
    task er(input logic [7:0] op, input logic we, input logic [3:1] lk,
            input int na, input logic [39:0] a, input int nx, input logic e);
        int k;
        @(negedge clk);
        wlat = we;
        lock = lk;
        run(op, 1, na, 64'(a), nx, 0);
        i_host.desel();
        chk("busy", 64'(busy), 64'(e));
        k = 0;
        while (busy === 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        chk("latch clear", 64'(wclr), 64'(e));
        wlat = 1'b0;
    endtask
    // Hang guard: the whole sequence needs about 6000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        rd("id", `FSR_OP_ID_SINGLE, 1, 24, 64'h0, 0, 32,
            {32'h0, MFR, DEV, MFR, DEV});
        rd("id swap", `FSR_OP_ID_SINGLE, 1, 24, 64'h1, 0, 16,
            {48'h0, DEV, MFR});
        rd("id dual", `FSR_OP_ID_DUAL, 2, 32, 64'hF0, 0, 32,
            {32'h0, MFR, DEV, MFR, DEV});
        rd("id quad", `FSR_OP_ID_QUAD, 4, 32, 64'h1F5, 4, 16,
            {48'h0, DEV, MFR});
        rd("unique", `FSR_OP_UNIQUE_ID, 1, 0, 64'h0, 32, 64, UID);
        rd("jedec", `FSR_OP_JEDEC_ID, 1, 0, 64'h0, 0, 24,
            {40'h0, MFR, TYP, CAP});
        run(`FSR_OP_PARAM_TABLE, 1, 24, 64'h7F, 8, 8);
        chk("table lane", 64'(oe), 64'h2);
        i_host.desel();
        er(ERA, 1'b0, 3'h0, 24, 40'h00_0000_1000, 0, 1'b0);
        er(ERA, 1'b1, 3'h1, 24, 40'h00_0000_1000, 0, 1'b0);
        er(ERA, 1'b1, 3'h0, 24, 40'h00_0000_4000, 0, 1'b0);
        er(ERA, 1'b1, 3'h0, 24, 40'h00_0000_1000, 1, 1'b0);
        er(ERA, 1'b1, 3'h1, 24, 40'h00_0000_2000, 0, 1'b1);
        er(ERA, 1'b1, 3'h0, 24, 40'h00_0000_3000, 0, 1'b1);
        er(PRG, 1'b1, 3'h0, 32, 40'h00_0010_00A5, 0, 1'b1);
        er(PRG, 1'b1, 3'h2, 32, 40'h00_0020_005A, 0, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
